// *** rtl/prtc_debounce.sv ***
// two-flop synchroniser and hold-time debounce for switch inputs
`timescale 1ns/1ps
`default_nettype none
module prtc_debounce #(
  parameter int unsigned W   = 4,
  parameter logic [31:0] CNT = prtc_pkg::DEBOUNCE_CYC
) (
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic [W-1:0] raw,
  output var  logic [W-1:0] clean_q
);

  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      logic        s1_q;
      logic        s2_q;
      logic [31:0] cnt_q;

      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          s1_q <= 1'b0;
          s2_q <= 1'b0;
        end else begin
          s1_q <= raw[i];
          s2_q <= s1_q;
        end
      end

      // a level must stand for the full count before it is believed
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          cnt_q      <= 32'h0;
          clean_q[i] <= 1'b0;
        end else if (s2_q == clean_q[i]) begin
          cnt_q <= 32'h0;
        end else if (cnt_q >= CNT - 32'h1) begin
          cnt_q      <= 32'h0;
          clean_q[i] <= s2_q;
        end else begin
          cnt_q <= cnt_q + 32'h1;
        end
      end
    end
  endgenerate

endmodule : prtc_debounce
`default_nettype wire

// *** rtl/prtc_pkg.sv ***
// shared constants and types of the pulse rate totaliser control
package prtc_pkg;

  localparam int unsigned CLK_HZ     = 20_000_000;
  localparam int unsigned CYC_PER_MS = CLK_HZ / 1000;

  // times in milliseconds
  localparam int unsigned START_DELAY_MS  = 100;
  localparam int unsigned LAMP_MS         = 2000;
  localparam int unsigned VERSION_MS      = 2000;
  localparam int unsigned REMOTE_RESET_MS = 1000;
  localparam int unsigned LOCAL_RESET_MS  = 2000;
  localparam int unsigned FLOW_ANIM_MS    = 2000;
  localparam int unsigned CALC_MS         = 500;
  localparam int unsigned FREQ_GATE_MS    = 1000;
  localparam int unsigned DEBOUNCE_MS     = 10;

  localparam logic [31:0] START_DELAY_CYC  = 32'(START_DELAY_MS * CYC_PER_MS);
  localparam logic [31:0] LAMP_CYC         = 32'(LAMP_MS * CYC_PER_MS);
  localparam logic [31:0] VERSION_CYC      = 32'(VERSION_MS * CYC_PER_MS);
  localparam logic [31:0] REMOTE_RESET_CYC = 32'(REMOTE_RESET_MS * CYC_PER_MS);
  localparam logic [31:0] LOCAL_RESET_CYC  = 32'(LOCAL_RESET_MS * CYC_PER_MS);
  localparam logic [31:0] FLOW_ANIM_CYC    = 32'(FLOW_ANIM_MS * CYC_PER_MS);
  localparam logic [31:0] CALC_CYC         = 32'(CALC_MS * CYC_PER_MS);
  localparam logic [31:0] FREQ_GATE_CYC    = 32'(FREQ_GATE_MS * CYC_PER_MS);
  localparam logic [31:0] DEBOUNCE_CYC     = 32'(DEBOUNCE_MS * CYC_PER_MS);

  // register byte offsets
  localparam logic [11:0] OFS_CTRL        = 12'h000;
  localparam logic [11:0] OFS_RATE_SCALE  = 12'h004;
  localparam logic [11:0] OFS_TOTAL_SCALE = 12'h008;
  localparam logic [11:0] OFS_CUTOFF      = 12'h00c;
  localparam logic [11:0] OFS_STATUS      = 12'h010;
  localparam logic [11:0] OFS_TOTAL       = 12'h014;
  localparam logic [11:0] OFS_GT_LO       = 12'h018;
  localparam logic [11:0] OFS_GT_HI       = 12'h01c;
  localparam logic [11:0] OFS_RATE        = 12'h020;
  localparam logic [11:0] OFS_FREQ        = 12'h024;

  // control register fields
  localparam int unsigned CTRL_LOC_EN  = 0;
  localparam int unsigned CTRL_TB_LSB  = 1;
  localparam int unsigned CTRL_GT_CLR  = 3;
  localparam int unsigned CTRL_CAL_OK  = 4;

  // reset values, rate limit and lamp-test pattern
  localparam logic [31:0] RST_SCALE  = 32'h0000_0001;
  localparam logic [31:0] RST_CUTOFF = 32'h0000_0000;
  localparam logic [19:0] RATE_MAX   = 20'hf423f;
  localparam logic [31:0] ALL_EIGHTS = 32'h8888_8888;

  typedef enum logic [1:0] {
    ST_DELAY = 2'b00,
    ST_LAMP  = 2'b01,
    ST_VER   = 2'b10,
    ST_RUN   = 2'b11
  } prtc_state_t;

  typedef enum logic [1:0] {
    TB_SEC  = 2'b00,
    TB_MIN  = 2'b01,
    TB_HOUR = 2'b10
  } prtc_tb_t;

  localparam logic [31:0] TB_SEC_MUL  = 32'h0000_0001;
  localparam logic [31:0] TB_MIN_MUL  = 32'h0000_003c;
  localparam logic [31:0] TB_HOUR_MUL = 32'h0000_0e10;

endpackage : prtc_pkg

// *** rtl/prtc_top.sv ***
// pulse rate totaliser control: init sequence, counting, display, apb
//
// The register addresses and the APB register port were decided locally.
`timescale 1ns/1ps
`default_nettype none
module prtc_top #(
  parameter logic [31:0] START_CYC  = prtc_pkg::START_DELAY_CYC,
  parameter logic [31:0] LAMP_CYC   = prtc_pkg::LAMP_CYC,
  parameter logic [31:0] VER_CYC    = prtc_pkg::VERSION_CYC,
  parameter logic [31:0] REMOTE_CYC = prtc_pkg::REMOTE_RESET_CYC,
  parameter logic [31:0] LOCAL_CYC  = prtc_pkg::LOCAL_RESET_CYC,
  parameter logic [31:0] FLOW_CYC   = prtc_pkg::FLOW_ANIM_CYC,
  parameter logic [31:0] CALC_CYC   = prtc_pkg::CALC_CYC,
  parameter logic [31:0] GATE_CYC   = prtc_pkg::FREQ_GATE_CYC,
  parameter logic [31:0] DEB_CYC    = prtc_pkg::DEBOUNCE_CYC,
  parameter logic [31:0] FW_PART    = 32'h0000_1234, // arbitrary value
  parameter logic [19:0] FW_VER     = 20'h00010      // arbitrary value
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output var  logic [31:0] prdata_q,
  output var  logic        pready_q,
  output var  logic        pslverr_q,
  input  wire logic        pulse_in,
  input  wire logic        btn_enter,
  input  wire logic        btn_up,
  input  wire logic        btn_down,
  input  wire logic        remote_contact,
  output var  logic [19:0] disp_rate_q,
  output var  logic [31:0] disp_total_q,
  output var  logic        seg_test_q,
  output var  logic        show_version_q,
  output var  logic        gt_ann_q,
  output var  logic        hold_ann_q,
  output var  logic        reset_ann_q,
  output var  logic        flow_ind_q
);

  function automatic logic [63:0] bcd_inc(input logic [63:0] v);
    logic [63:0] r;
    logic        c;
    r = v;
    c = 1'b1;
    for (int i = 0; i < 16; i++) begin
      if (c) begin
        if (r[4*i +: 4] == 4'h9) begin
          r[4*i +: 4] = 4'h0;
        end else begin
          r[4*i +: 4] = r[4*i +: 4] + 4'h1;
          c = 1'b0;
        end
      end
    end
    return r;
  endfunction : bcd_inc

  function automatic logic addr_ok(input logic [11:0] a);
    return a <= prtc_pkg::OFS_FREQ && a[1:0] == 2'b00;
  endfunction : addr_ok

  ////////////////////////////////////////////////////////////////////////////
  // inputs
  logic       pulse_s1_q, pulse_s2_q, pulse_s3_q;
  logic [3:0] sw_q;
  logic       enter, up, down, remote;
  logic       pulse_edge;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pulse_s1_q <= 1'b0;
      pulse_s2_q <= 1'b0;
      pulse_s3_q <= 1'b0;
    end else begin
      pulse_s1_q <= pulse_in;
      pulse_s2_q <= pulse_s1_q;
      pulse_s3_q <= pulse_s2_q;
    end
  end
  // no filter on the pulse path so 5 kHz sources still count
  assign pulse_edge = pulse_s2_q & ~pulse_s3_q;

  prtc_debounce #(.W(4), .CNT(DEB_CYC)) u_deb (
    .pclk    (pclk),
    .presetn (presetn),
    .raw     ({remote_contact, btn_down, btn_up, btn_enter}),
    .clean_q (sw_q)
  );
  assign {remote, down, up, enter} = sw_q;

  ////////////////////////////////////////////////////////////////////////////
  // registers
  logic [31:0] ctrl_q, rate_scale_q, total_scale_q, cutoff_q;
  logic [31:0] total_q, freq_q;
  logic [63:0] gt_q;
  logic [19:0] rate_q;
  prtc_pkg::prtc_state_t state_q;
  logic        hold, inhibit, total_clear, run, wr_acc;

  assign wr_acc = psel & penable & pready_q & pwrite & ~pslverr_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q        <= 32'h0;
      rate_scale_q  <= prtc_pkg::RST_SCALE;
      total_scale_q <= prtc_pkg::RST_SCALE;
      cutoff_q      <= prtc_pkg::RST_CUTOFF;
    end else begin
      ctrl_q[prtc_pkg::CTRL_GT_CLR] <= 1'b0;
      if (wr_acc) begin
        if (paddr == prtc_pkg::OFS_CTRL) begin
          ctrl_q <= pwdata & 32'h0000_001f;
        end else if (paddr == prtc_pkg::OFS_RATE_SCALE) begin
          rate_scale_q <= pwdata;
        end else if (paddr == prtc_pkg::OFS_TOTAL_SCALE) begin
          total_scale_q <= pwdata;
        end else if (paddr == prtc_pkg::OFS_CUTOFF) begin
          cutoff_q <= pwdata;
        end
      end
    end
  end

  // answers in the first access cycle; reads are sampled in setup
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= 32'h0;
    end else begin
      pready_q  <= psel & ~penable;
      pslverr_q <= psel & ~penable & ~addr_ok(paddr);
      if (psel & ~penable & ~pwrite) begin
        if (paddr == prtc_pkg::OFS_CTRL) begin
          prdata_q <= ctrl_q;
        end else if (paddr == prtc_pkg::OFS_RATE_SCALE) begin
          prdata_q <= rate_scale_q;
        end else if (paddr == prtc_pkg::OFS_TOTAL_SCALE) begin
          prdata_q <= total_scale_q;
        end else if (paddr == prtc_pkg::OFS_CUTOFF) begin
          prdata_q <= cutoff_q;
        end else if (paddr == prtc_pkg::OFS_STATUS) begin
          prdata_q <= {24'h0, inhibit, total_clear, hold, flow_ind_q,
                       2'b00, state_q};
        end else if (paddr == prtc_pkg::OFS_TOTAL) begin
          prdata_q <= total_q;
        end else if (paddr == prtc_pkg::OFS_GT_LO) begin
          prdata_q <= gt_q[31:0];
        end else if (paddr == prtc_pkg::OFS_GT_HI) begin
          prdata_q <= gt_q[63:32];
        end else if (paddr == prtc_pkg::OFS_RATE) begin
          prdata_q <= {12'h0, rate_q};
        end else if (paddr == prtc_pkg::OFS_FREQ) begin
          prdata_q <= freq_q;
        end else begin
          prdata_q <= 32'h0;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // power-up sequence
  logic [31:0] init_cnt_q;
  logic [31:0] init_lim;

  always_comb begin
    case (state_q)
      prtc_pkg::ST_DELAY: init_lim = START_CYC;
      prtc_pkg::ST_LAMP:  init_lim = LAMP_CYC;
      default:            init_lim = VER_CYC;
    endcase
  end

  // software loads calibration during the delay; run also waits for cal_ok
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q    <= prtc_pkg::ST_DELAY;
      init_cnt_q <= 32'h0;
    end else if (state_q != prtc_pkg::ST_RUN) begin
      if (init_cnt_q >= init_lim - 32'h1) begin
        if (state_q != prtc_pkg::ST_VER || ctrl_q[prtc_pkg::CTRL_CAL_OK]) begin
          init_cnt_q <= 32'h0;
          case (state_q)
            prtc_pkg::ST_DELAY: state_q <= prtc_pkg::ST_LAMP;
            prtc_pkg::ST_LAMP:  state_q <= prtc_pkg::ST_VER;
            default:            state_q <= prtc_pkg::ST_RUN;
          endcase
        end
      end else begin
        init_cnt_q <= init_cnt_q + 32'h1;
      end
    end
  end
  assign run = state_q == prtc_pkg::ST_RUN;

  ////////////////////////////////////////////////////////////////////////////
  // resets, inhibit and timers
  logic [31:0] rem_cnt_q, loc_cnt_q, flow_cnt_q, calc_cnt_q, gate_cnt_q;
  logic        loc_press, calc_tick, gate_tick;

  assign loc_press = ctrl_q[prtc_pkg::CTRL_LOC_EN] & up & down & ~enter;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rem_cnt_q <= 32'h0;
      loc_cnt_q <= 32'h0;
    end else begin
      if (!(remote && run)) rem_cnt_q <= 32'h0;
      else if (rem_cnt_q < REMOTE_CYC) rem_cnt_q <= rem_cnt_q + 32'h1;
      if (!(loc_press && run)) loc_cnt_q <= 32'h0;
      else if (loc_cnt_q < LOCAL_CYC) loc_cnt_q <= loc_cnt_q + 32'h1;
    end
  end
  // clear holds for as long as the qualifying press or contact stays
  assign total_clear = rem_cnt_q >= REMOTE_CYC || loc_cnt_q >= LOCAL_CYC;
  assign inhibit     = remote;
  assign hold        = freq_q < cutoff_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flow_cnt_q <= 32'h0;
    end else if (pulse_edge) begin
      flow_cnt_q <= FLOW_CYC;
    end else if (flow_cnt_q != 32'h0) begin
      flow_cnt_q <= flow_cnt_q - 32'h1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      calc_cnt_q <= 32'h0;
      gate_cnt_q <= 32'h0;
    end else begin
      calc_cnt_q <= calc_tick ? 32'h0 : calc_cnt_q + 32'h1;
      gate_cnt_q <= gate_tick ? 32'h0 : gate_cnt_q + 32'h1;
    end
  end
  assign calc_tick = calc_cnt_q >= CALC_CYC - 32'h1;
  assign gate_tick = gate_cnt_q >= GATE_CYC - 32'h1;

  ////////////////////////////////////////////////////////////////////////////
  // totalisation: pulses become units, committed twice a second
  logic [31:0] resid_q, pend_q, commit_q, pulse_win_q;
  logic        count_en, unit, drain;
  logic [63:0] total_inc;

  // runs regardless of buttons, so menu work never stops counting
  assign count_en = run & pulse_edge & ~inhibit & ~hold;
  assign unit     = count_en && resid_q + 32'h1 >= total_scale_q;
  assign drain    = commit_q != 32'h0;
  assign total_inc = bcd_inc({32'h0, total_q});

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      resid_q  <= 32'h0;
      pend_q   <= 32'h0;
      commit_q <= 32'h0;
    end else begin
      if (unit) resid_q <= 32'h0;
      else if (count_en) resid_q <= resid_q + 32'h1;
      if (calc_tick) pend_q <= {31'h0, unit};
      else pend_q <= pend_q + {31'h0, unit};
      if (total_clear) commit_q <= 32'h0;
      else if (calc_tick) commit_q <= commit_q + pend_q - {31'h0, drain};
      else commit_q <= commit_q - {31'h0, drain};
    end
  end

  // one unit per clock keeps the bcd adder small; a window drains fast
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      total_q <= 32'h0;
      gt_q    <= 64'h0;
    end else begin
      if (total_clear) total_q <= 32'h0;
      else if (drain) total_q <= total_inc[31:0];
      if (ctrl_q[prtc_pkg::CTRL_GT_CLR]) gt_q <= 64'h0;
      else if (drain) gt_q <= bcd_inc(gt_q);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // frequency and rate: serial divide once per gate
  logic [31:0] tb_mul, div_n_q, div_r_q, r_sh, num;
  logic [63:0] prod;
  logic [5:0]  div_cnt_q;
  logic        r_ge;

  always_comb begin
    case (prtc_pkg::prtc_tb_t'(ctrl_q[prtc_pkg::CTRL_TB_LSB +: 2]))
      prtc_pkg::TB_MIN:  tb_mul = prtc_pkg::TB_MIN_MUL;
      prtc_pkg::TB_HOUR: tb_mul = prtc_pkg::TB_HOUR_MUL;
      default:           tb_mul = prtc_pkg::TB_SEC_MUL;
    endcase
  end
  assign prod = freq_q * tb_mul;
  assign num  = prod[31:0];
  assign r_sh = {div_r_q[30:0], div_n_q[31]};
  assign r_ge = r_sh >= rate_scale_q;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pulse_win_q <= 32'h0;
      freq_q      <= 32'h0;
    end else if (gate_tick) begin
      freq_q      <= pulse_win_q + {31'h0, pulse_edge};
      pulse_win_q <= 32'h0;
    end else begin
      pulse_win_q <= pulse_win_q + {31'h0, pulse_edge};
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_n_q   <= 32'h0;
      div_r_q   <= 32'h0;
      div_cnt_q <= 6'h0;
      rate_q    <= 20'h0;
    end else if (gate_tick) begin
      div_n_q   <= 32'h0;
      div_r_q   <= 32'h0;
      div_cnt_q <= 6'h21;
    end else if (div_cnt_q == 6'h21) begin
      div_n_q   <= num;
      div_cnt_q <= 6'h20;
    end else if (div_cnt_q != 6'h0) begin
      div_r_q   <= r_ge ? r_sh - rate_scale_q : r_sh;
      div_n_q   <= {div_n_q[30:0], r_ge};
      div_cnt_q <= div_cnt_q - 6'h1;
    end else if (rate_scale_q == 32'h0 || div_n_q > 32'(prtc_pkg::RATE_MAX)) begin
      rate_q <= prtc_pkg::RATE_MAX;
    end else begin
      rate_q <= div_n_q[19:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // displays
  logic gt_lo, gt_hi, ver_req;

  assign gt_lo   = run & enter & down & ~up;
  assign gt_hi   = run & enter & up & ~down;
  assign ver_req = run & down & ~up & ~enter;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      disp_rate_q    <= 20'h0;
      disp_total_q   <= 32'h0;
      seg_test_q     <= 1'b0;
      show_version_q <= 1'b0;
      gt_ann_q       <= 1'b0;
      hold_ann_q     <= 1'b0;
      reset_ann_q    <= 1'b0;
      flow_ind_q     <= 1'b0;
    end else begin
      seg_test_q     <= state_q == prtc_pkg::ST_LAMP;
      show_version_q <= state_q == prtc_pkg::ST_VER || ver_req;
      gt_ann_q       <= gt_lo | gt_hi;
      hold_ann_q     <= run & hold;
      reset_ann_q    <= total_clear;
      flow_ind_q     <= flow_cnt_q != 32'h0;
      if (state_q == prtc_pkg::ST_LAMP) begin
        disp_rate_q  <= prtc_pkg::RATE_MAX;
        disp_total_q <= prtc_pkg::ALL_EIGHTS;
      end else if (state_q == prtc_pkg::ST_VER || ver_req) begin
        disp_rate_q  <= FW_VER;
        disp_total_q <= FW_PART;
      end else begin
        disp_rate_q <= run ? rate_q : 20'h0;
        if (gt_lo) disp_total_q <= gt_q[31:0];
        else if (gt_hi) disp_total_q <= gt_q[63:32];
        else disp_total_q <= run ? total_q : 32'h0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_lamp_to_ver;
    state_q == prtc_pkg::ST_LAMP ##1 state_q == prtc_pkg::ST_VER;
  endsequence

  chk_lamp_segments: assert property (
    state_q == prtc_pkg::ST_LAMP |=> seg_test_q && disp_total_q == 32'h8888_8888)
    else $error("lamp test not shown");
  chk_version_after: assert property (
    s_lamp_to_ver |=> show_version_q && disp_total_q == FW_PART)
    else $error("version not shown after lamp test");
  chk_count_gate: assert property (
    !run |=> resid_q == $past(resid_q) && pend_q == 32'h0 || calc_tick)
    else $error("counting before run");
  chk_gt_low: assert property (
    gt_lo |=> gt_ann_q && disp_total_q == $past(gt_q[31:0]))
    else $error("grand total low half not shown");
  chk_gt_high: assert property (
    gt_hi |=> gt_ann_q && disp_total_q == $past(gt_q[63:32]))
    else $error("grand total high half not shown");
  chk_local_clear: assert property (
    loc_cnt_q >= LOCAL_CYC |=> total_q == 32'h0 && reset_ann_q)
    else $error("local reset did not clear");
  chk_version_down: assert property (
    ver_req |=> show_version_q)
    else $error("down did not show version");
  chk_remote_inhibit: assert property (
    remote && pulse_edge |=> resid_q == $past(resid_q))
    else $error("pulse counted while inhibited");
  chk_flow_retrig: assert property (
    pulse_edge |=> flow_cnt_q == FLOW_CYC ##1 flow_ind_q)
    else $error("flow indicator not retriggered");
  chk_hold_lamp: assert property (
    run && freq_q < cutoff_q |=> hold_ann_q)
    else $error("hold lamp off below cutoff");
  chk_remote_clear: assert property (
    rem_cnt_q >= REMOTE_CYC |=> total_q == 32'h0 && reset_ann_q)
    else $error("remote reset did not clear");

endmodule : prtc_top
`default_nettype wire

// *** sim/prtc_src.sv ***
// pulse transducer model driving the single counted input pin
`timescale 1ns/1ps
`default_nettype none
module prtc_src (
  input  wire logic       pclk,
  input  wire logic       go,
  input  wire logic [7:0] n_pulse,
  output var  logic       busy_q,
  output var  logic       pulse_in
);
  logic [7:0] left_q;
  logic [2:0] ph_q;
  initial begin
    busy_q = 1'h0;
    pulse_in = 1'h0;
  end
  ////////////////////////////////////////////////////////////////////////////
  // one pin only, rests low; each pulse fully low then fully high
  always @(posedge pclk) begin
    if (go && !busy_q) begin
      left_q <= n_pulse;
      busy_q <= (n_pulse != 8'h00);
      ph_q <= 3'h0;
      pulse_in <= 1'h0;
    end else if (busy_q) begin
      ph_q <= ph_q + 3'h1;
      pulse_in <= ph_q[2];
      if (ph_q == 3'h7) begin
        left_q <= left_q - 8'h01;
        busy_q <= (left_q != 8'h01);
      end
    end else begin
      pulse_in <= 1'h0;
    end
  end
endmodule : prtc_src
`default_nettype wire

// *** sim/tb.sv ***
// self-checking bench of the pulse rate totaliser control
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic        pclk, presetn, psel, penable, pwrite, go, er, ok;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata_q, rd, disp_total_q;
  logic        pready_q, pslverr_q, pulse_in, busy_q, remote_contact;
  logic        btn_enter, btn_up, btn_down, seg_test_q, show_version_q;
  logic        gt_ann_q, hold_ann_q, reset_ann_q, flow_ind_q;
  logic [19:0] disp_rate_q;
  logic [7:0]  n_pulse;
  logic [37:0] rows [4];
  int          n_fail, tests_run, c;
  wire  [5:0]  fl = {flow_ind_q, reset_ann_q, hold_ann_q, gt_ann_q,
                     show_version_q, seg_test_q};
  // shortened times so the whole run stays small
  localparam logic [31:0] T_START = 32'h0a, T_LAMP = 32'h14, T_VER = 32'h14;
  localparam logic [31:0] T_REM = 32'h1e, T_LOC = 32'h28, T_FLOW = 32'h32;
  localparam logic [31:0] T_CALC = 32'h10, T_GATE = 32'h64, T_DEB = 32'h03;
  prtc_top #(.START_CYC(T_START), .LAMP_CYC(T_LAMP), .VER_CYC(T_VER),
    .REMOTE_CYC(T_REM), .LOCAL_CYC(T_LOC), .FLOW_CYC(T_FLOW),
    .CALC_CYC(T_CALC), .GATE_CYC(T_GATE), .DEB_CYC(T_DEB)) dut (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata_q,
    .pready_q, .pslverr_q, .pulse_in, .btn_enter, .btn_up, .btn_down,
    .remote_contact, .disp_rate_q, .disp_total_q, .seg_test_q,
    .show_version_q, .gt_ann_q, .hold_ann_q, .reset_ann_q, .flow_ind_q);
  prtc_src src (.pclk, .go, .n_pulse, .busy_q, .pulse_in);
  ////////////////////////////////////////////////////////////////////////////
  task automatic end_sim;
    $display("compares %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : end_sim
  task automatic chk(input string nm, input logic [31:0] e, g);
    tests_run++;
    if (g !== e) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  // bounded wait for one display flag; c returns cycles spent
  task automatic wt(input int b, input logic v, input int lim);
    c = 0;
    while (fl[b] !== v) begin
      @(posedge pclk);
      c++;
      if (c > lim) begin
        chk("flag wait", 32'(b), 32'hffff_ffff);
        end_sim;
      end
    end
  endtask : wt
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    int k;
    k = 0;
    @(posedge pclk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    do begin
      @(posedge pclk);
      k++;
    end while (pready_q !== 1'h1 && k < 20);
    rd = prdata_q;
    er = pslverr_q;
    psel <= 1'h0;
    penable <= 1'h0;
    if (pready_q !== 1'h1) begin
      chk("pready", 32'h1, 32'h0);
      end_sim;
    end
  endtask : apb
  task automatic pulses(input logic [7:0] n);
    @(posedge pclk);
    go <= 1'h1;
    n_pulse <= n;
    @(posedge pclk);
    go <= 1'h0;
    @(posedge pclk);
    wt(0, 1'h0, 0);
    for (c = 0; busy_q !== 1'h0 && c < 4000; c++) @(posedge pclk);
    if (busy_q !== 1'h0) begin
      chk("pulse source", 32'h0, 32'h1);
      end_sim;
    end
  endtask : pulses
  task automatic btn(input logic [2:0] b);
    @(posedge pclk);
    {btn_enter, btn_up, btn_down} <= b;
    repeat (10) @(posedge pclk);
  endtask : btn
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    pclk = 1'h0;
    forever #25 pclk = ~pclk;
  end
  initial begin
    {presetn, psel, penable, pwrite, go, remote_contact} = 6'h00;
    {btn_enter, btn_up, btn_down, paddr, pwdata, n_pulse} = 55'h0;
    n_fail = 0;
    tests_run = 0;
    // enter, up, down, grand ann, version, check total, total value
    rows = '{{6'b000001, 32'h5}, {6'b101101, 32'h5},
             {6'b110101, 32'h0}, {6'b001010, 32'h0}};
    repeat (4) @(posedge pclk);
    presetn <= 1'h1;
    @(posedge pclk);
    chk("total at reset", 32'h0, disp_total_q);
    apb(1'h0, prtc_pkg::OFS_RATE_SCALE, 32'h0);
    chk("rate scale", 32'h1, rd);
    apb(1'h1, prtc_pkg::OFS_CTRL, 32'h11);
    wt(0, 1'h1, 40);
    wt(0, 1'h0, 40);
    chk("lamp time ok", 32'h1, 32'(c >= 19 && c <= 21));
    wt(1, 1'h1, 3);
    wt(1, 1'h0, 40);
    chk("version time ok", 32'h1, 32'(c >= 19 && c <= 21));
    apb(1'h0, prtc_pkg::OFS_STATUS, 32'h0);
    chk("state", 32'h3, {30'h0, rd[1:0]});
    $display("power-up sequence done");
    apb(1'h1, prtc_pkg::OFS_TOTAL_SCALE, 32'h2);
    pulses(8'h0a);
    repeat (30) @(posedge pclk);
    chk("flow", 32'h1, flow_ind_q);
    repeat (60) @(posedge pclk);
    chk("flow", 32'h0, flow_ind_q);
    chk("total", 32'h5, disp_total_q);
    foreach (rows[i]) begin
      btn(rows[i][37:35]);
      chk("gt ann", rows[i][34], gt_ann_q);
      chk("version", rows[i][33], show_version_q);
      if (rows[i][32]) chk("total", rows[i][31:0], disp_total_q);
      $display("button row %0d done", i);
    end
    btn(3'h0);
    apb(1'h1, prtc_pkg::OFS_CUTOFF, 32'h1);
    wt(3, 1'h1, 300);
    chk("hold", 32'h1, hold_ann_q);
    apb(1'h1, prtc_pkg::OFS_CUTOFF, 32'h0);
    wt(3, 1'h0, 300);
    @(posedge pclk);
    remote_contact <= 1'h1;
    pulses(8'h04);
    wt(4, 1'h1, 100);
    // the total display follows the cleared total one cycle later
    @(posedge pclk);
    chk("remote clear", 32'h0, disp_total_q);
    @(posedge pclk);
    remote_contact <= 1'h0;
    wt(4, 1'h0, 40);
    repeat (40) @(posedge pclk);
    chk("inhibited", 32'h0, disp_total_q);
    apb(1'h0, prtc_pkg::OFS_GT_LO, 32'h0);
    chk("grand total", 32'h5, rd);
    $display("remote contact done");
    pulses(8'h04);
    repeat (40) @(posedge pclk);
    chk("total", 32'h2, disp_total_q);
    btn(3'h3);
    wt(4, 1'h1, 80);
    @(posedge pclk);
    chk("local clear", 32'h0, disp_total_q);
    btn(3'h0);
    apb(1'h1, prtc_pkg::OFS_CTRL, 32'h19);
    apb(1'h0, prtc_pkg::OFS_GT_LO, 32'h0);
    chk("grand total cleared", 32'h0, rd);
    apb(1'h0, prtc_pkg::OFS_CTRL, 32'h0);
    chk("ctrl", 32'h11, rd);
    // a pulse each 8 cycles puts 12 or 13 pulses in one gate
    apb(1'h1, prtc_pkg::OFS_CTRL, 32'h13);
    @(posedge pclk);
    go <= 1'h1;
    n_pulse <= 8'hff;
    @(posedge pclk);
    go <= 1'h0;
    repeat (300) @(posedge pclk);
    ok = disp_rate_q == 20'h002d0 || disp_rate_q == 20'h0030c;
    chk("rate x60", 32'h1, {31'h0, ok});
    apb(1'h1, prtc_pkg::OFS_CTRL, 32'h15);
    repeat (250) @(posedge pclk);
    ok = disp_rate_q == 20'h0a8c0 || disp_rate_q == 20'h0b6d0;
    chk("rate x3600", 32'h1, {31'h0, ok});
    presetn <= 1'h0;
    repeat (2) @(posedge pclk);
    chk("rate in reset", 32'h0, {12'h0, disp_rate_q});
    chk("total in reset", 32'h0, disp_total_q);
    presetn <= 1'h1;
    @(posedge pclk);
    $display("rate, grand clear and second reset done");
    apb(1'h0, 12'h028, 32'h0);
    chk("slverr", 32'h1, {31'h0, er});
    $display("local reset and bus error done");
    end_sim;
  end
endmodule : tb
`default_nettype wire
